// ==== shared/msrrc_pkg.sv ====
// Package for the range and rate configuration slice: offsets, fields, resets, codes.
// Assumes an 8-bit register port addressed by 7-bit register numbers.
package msrrc_pkg;
    // Register offsets
    localparam logic [6:0] ADDR_ACCEL_FULL_SCALE  = 7'h41;
    localparam logic [6:0] ADDR_GYRO_RATE_FILTER  = 7'h42;
    localparam logic [6:0] ADDR_GYRO_FULL_SCALE   = 7'h43;
    localparam logic [6:0] ADDR_MAG_POLL_RATE     = 7'h44;
    // Register slots, indexed from the lowest offset
    localparam int         NUM_CFG_REGS           = 4;
    localparam int         IDX_ACCEL_FULL_SCALE   = 0;
    localparam int         IDX_GYRO_RATE_FILTER   = 1;
    localparam int         IDX_GYRO_FULL_SCALE    = 2;
    localparam int         IDX_MAG_POLL_RATE      = 3;
    // Field positions inside the registers
    localparam int         ACC_RANGE_MSB          = 3;
    localparam int         ACC_RANGE_LSB          = 0;
    localparam int         GYR_BWP_MSB            = 5;
    localparam int         GYR_BWP_LSB            = 4;
    localparam int         GYR_ODR_MSB            = 3;
    localparam int         GYR_ODR_LSB            = 0;
    localparam int         GYR_RANGE_MSB          = 2;
    localparam int         GYR_RANGE_LSB          = 0;
    localparam int         MAG_ODR_MSB            = 3;
    localparam int         MAG_ODR_LSB            = 0;
    // Read data shown when nothing is read
    localparam logic [7:0] RDATA_IDLE             = 8'h00;
    // Reset values
    localparam logic [7:0] RST_ACCEL_FULL_SCALE   = 8'h03;
    localparam logic [7:0] RST_GYRO_RATE_FILTER   = 8'h28;
    localparam logic [7:0] RST_GYRO_FULL_SCALE    = 8'h00;
    localparam logic [7:0] RST_MAG_POLL_RATE      = 8'h0B;
    // Writable field masks; reserved bits read zero
    localparam logic [7:0] MASK_ACCEL_FULL_SCALE  = 8'h0F;
    localparam logic [7:0] MASK_GYRO_RATE_FILTER  = 8'h3F;
    localparam logic [7:0] MASK_GYRO_FULL_SCALE   = 8'h07;
    localparam logic [7:0] MASK_MAG_POLL_RATE     = 8'h0F;
    // Accelerometer range codes
    localparam logic [3:0] ACC_CODE_2G            = 4'h3;
    localparam logic [3:0] ACC_CODE_4G            = 4'h5;
    localparam logic [3:0] ACC_CODE_8G            = 4'h8;
    localparam logic [3:0] ACC_CODE_16G           = 4'hC;
    // Gyro rate selector limits, rate = 100 Hz / 2^(8 - sel)
    localparam logic [3:0] GYR_ODR_MIN            = 4'h6;
    localparam logic [3:0] GYR_ODR_MAX            = 4'hD;
    localparam logic [3:0] GYR_ODR_BASE           = 4'h8;
    // Gyro bandwidth coefficient: only codes 0..2 carry a bandwidth number
    localparam logic [1:0] GYR_BWP_MAX            = 2'h2;
    // Gyro range code limit
    localparam logic [2:0] GYR_RANGE_MAX          = 3'h4;
    // Mag poll selector limits, rate = 50 Hz / 2^(7 - sel)
    localparam logic [3:0] MAG_ODR_MIN            = 4'h1;
    localparam logic [3:0] MAG_ODR_MAX            = 4'hB;
    localparam logic [3:0] MAG_ODR_BASE           = 4'h7;
    // Error codes
    localparam logic [3:0] ERR_NONE               = 4'h0;
    localparam logic [3:0] ERR_GYRO_RATE_FILTER_CONFIG           = 4'h1;
    localparam logic [3:0] ERR_MAGNETOMETER_POLL_RATE           = 4'h2;
    localparam logic [3:0] ERR_GYR_RANGE          = 4'h3;

    // Decoded accelerometer range
    typedef enum logic [1:0] {
        MSRRC_ACC_2G  = 2'b00,
        MSRRC_ACC_4G  = 2'b01,
        MSRRC_ACC_8G  = 2'b10,
        MSRRC_ACC_16G = 2'b11
    } msrrc_acc_range_t;
endpackage

// ==== rtl/msrrc_top.sv ====
// Range and rate configuration registers of the inertial sensor.
// Assumes a synchronous register port (one-cycle write/read strobes) from
// the serial host interface, and that the status block owns data-ready flags.
// Decoded settings and the error code are registered, one cycle after a write.
// Reset is synchronous; no power-mode input reaches this slice.
`timescale 1ns/1ps
`default_nettype none

module msrrc_top
    import msrrc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    output logic      [1:0]  accel_range_sel,
    output logic      [1:0]  gyro_bw_coef,
    output logic      [3:0]  gyro_rate_sel,
    output logic             gyro_rate_valid,
    output logic      [2:0]  gyro_range_sel,
    output logic      [3:0]  mag_poll_sel,
    output logic             mag_poll_valid,
    output logic      [3:0]  config_err_code,
    output logic             range_changed
);

    // Register storage, one slot per offset starting at the lowest one
    logic             [7:0] cfg_ff     [NUM_CFG_REGS];
    logic             [7:0] nxt_cfg    [NUM_CFG_REGS];

    // Registered port answers
    logic             [7:0] rdata_ff;
    logic                   hit_ff;
    logic                   chg_ff;
    logic             [3:0] err_ff;

    // Registered decoded configuration
    msrrc_acc_range_t       acc_ff;
    logic             [1:0] bwp_ff;
    logic             [3:0] godr_ff;
    logic                   gval_ff;
    logic             [2:0] grng_ff;
    logic             [3:0] modr_ff;
    logic                   mval_ff;

    // Reset and writable-bit tables, in slot order
    localparam logic [7:0] RST_VAL  [NUM_CFG_REGS] = '{RST_ACCEL_FULL_SCALE, RST_GYRO_RATE_FILTER,
                                                       RST_GYRO_FULL_SCALE, RST_MAG_POLL_RATE};
    localparam logic [7:0] MASK_VAL [NUM_CFG_REGS] = '{MASK_ACCEL_FULL_SCALE, MASK_GYRO_RATE_FILTER,
                                                       MASK_GYRO_FULL_SCALE, MASK_MAG_POLL_RATE};

    // Field views of the reset contents, so the derived flops agree with the registers
    localparam logic [3:0] RST_ACC_CODE = RST_ACCEL_FULL_SCALE[ACC_RANGE_MSB:ACC_RANGE_LSB];
    localparam logic [1:0] RST_BWP      = RST_GYRO_RATE_FILTER[GYR_BWP_MSB:GYR_BWP_LSB];
    localparam logic [3:0] RST_GODR     = RST_GYRO_RATE_FILTER[GYR_ODR_MSB:GYR_ODR_LSB];
    localparam logic [2:0] RST_GRNG     = RST_GYRO_FULL_SCALE[GYR_RANGE_MSB:GYR_RANGE_LSB];
    localparam logic [3:0] RST_MODR     = RST_MAG_POLL_RATE[MAG_ODR_MSB:MAG_ODR_LSB];

    // Address decode, one-hot over the slots; shared by write and read paths
    function automatic logic [3:0] dec_sel(input logic [6:0] a);
        dec_sel = {a == ADDR_MAG_POLL_RATE, a == ADDR_GYRO_FULL_SCALE,
                   a == ADDR_GYRO_RATE_FILTER, a == ADDR_ACCEL_FULL_SCALE};
    endfunction

    // Accelerometer selector decode; unknown codes fall back to 2 g
    function automatic msrrc_acc_range_t acc_decode(input logic [3:0] c);
        acc_decode = (c == ACC_CODE_4G)  ? MSRRC_ACC_4G :
                     (c == ACC_CODE_8G)  ? MSRRC_ACC_8G :
                     (c == ACC_CODE_16G) ? MSRRC_ACC_16G :
                     MSRRC_ACC_2G;
    endfunction

    // Gyro rate legality; the rate follows from the selector alone
    function automatic logic gyr_rate_ok(input logic [3:0] s);
        gyr_rate_ok = (s >= GYR_ODR_MIN) && (s <= GYR_ODR_MAX);
    endfunction

    // Mag poll legality; reserved low and high codes give no poll rate
    function automatic logic mag_rate_ok(input logic [3:0] s);
        mag_rate_ok = (s >= MAG_ODR_MIN) && (s <= MAG_ODR_MAX);
    endfunction

    // Port decode
    wire logic [3:0] sel      = dec_sel(reg_addr);
    wire logic       any_sel  = |sel;
    wire logic       port_acc = reg_rd || reg_wr;
    wire logic [3:0] wr_sel   = sel & {4{reg_wr}};

    // Per-slot next value; reserved bits are dropped on the way in, so they
    // read back as zero even when software ignores the write-zero rule
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CFG_REGS; gi++) begin : g_reg
            assign nxt_cfg[gi] = wr_sel[gi] ? (reg_wdata & MASK_VAL[gi]) : cfg_ff[gi];
            always_ff @(posedge clk) begin
                if (reset) begin
                    cfg_ff[gi] <= RST_VAL[gi];
                end else begin
                    cfg_ff[gi] <= nxt_cfg[gi];
                end
            end
        end
    endgenerate

    // Field views of the next contents; derived outputs follow a write at the same edge
    wire logic [3:0] nxt_acc_code = nxt_cfg[IDX_ACCEL_FULL_SCALE][ACC_RANGE_MSB:ACC_RANGE_LSB];
    wire logic [1:0] nxt_bwp      = nxt_cfg[IDX_GYRO_RATE_FILTER][GYR_BWP_MSB:GYR_BWP_LSB];
    wire logic [3:0] nxt_godr     = nxt_cfg[IDX_GYRO_RATE_FILTER][GYR_ODR_MSB:GYR_ODR_LSB];
    wire logic [2:0] nxt_grng     = nxt_cfg[IDX_GYRO_FULL_SCALE][GYR_RANGE_MSB:GYR_RANGE_LSB];
    wire logic [3:0] nxt_modr     = nxt_cfg[IDX_MAG_POLL_RATE][MAG_ODR_MSB:MAG_ODR_LSB];
    wire msrrc_acc_range_t nxt_acc = acc_decode(nxt_acc_code);

    // Legality of the next settings; no power-mode input exists, by intent
    wire logic nxt_gval = gyr_rate_ok(nxt_godr);
    wire logic nxt_mval = mag_rate_ok(nxt_modr);
    wire logic nxt_bok  = nxt_bwp <= GYR_BWP_MAX;
    wire logic nxt_rok  = nxt_grng <= GYR_RANGE_MAX;

    // Error code is a level of the current settings, not sticky; gyro conf
    // outranks mag, which outranks gyro range, so only one code shows at a time
    wire logic [3:0] nxt_err = !(nxt_gval && nxt_bok) ? ERR_GYRO_RATE_FILTER_CONFIG :
                               !nxt_mval              ? ERR_MAGNETOMETER_POLL_RATE :
                               !nxt_rok               ? ERR_GYR_RANGE : ERR_NONE;

    // Range-change notice only; data-ready flags live in the status block
    // and nothing here can clear them
    wire logic nxt_chg = wr_sel[IDX_ACCEL_FULL_SCALE] || wr_sel[IDX_GYRO_FULL_SCALE];

    // Read mux; wr and rd together return the old contents, since cfg_ff is read
    wire logic [7:0] rd_mux    = sel[IDX_ACCEL_FULL_SCALE] ? cfg_ff[IDX_ACCEL_FULL_SCALE] :
                                 sel[IDX_GYRO_RATE_FILTER] ? cfg_ff[IDX_GYRO_RATE_FILTER] :
                                 sel[IDX_GYRO_FULL_SCALE]  ? cfg_ff[IDX_GYRO_FULL_SCALE] :
                                 sel[IDX_MAG_POLL_RATE]    ? cfg_ff[IDX_MAG_POLL_RATE] : RDATA_IDLE;
    wire logic [7:0] nxt_rdata = reg_rd ? rd_mux : RDATA_IDLE;
    wire logic       nxt_hit   = port_acc && any_sel;

    // Port answers stand for one cycle only
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= RDATA_IDLE;
            hit_ff   <= 1'b0;
            chg_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            hit_ff   <= nxt_hit;
            chg_ff   <= nxt_chg;
        end
    end

    // Error code; reset contents are legal, so no code after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            err_ff <= ERR_NONE;
        end else begin
            err_ff <= nxt_err;
        end
    end

    // Range selections
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_ff  <= acc_decode(RST_ACC_CODE);
            grng_ff <= RST_GRNG;
        end else begin
            acc_ff  <= nxt_acc;
            grng_ff <= nxt_grng;
        end
    end

    // Gyro rate and filter settings
    always_ff @(posedge clk) begin
        if (reset) begin
            bwp_ff  <= RST_BWP;
            godr_ff <= RST_GODR;
            gval_ff <= gyr_rate_ok(RST_GODR);
        end else begin
            bwp_ff  <= nxt_bwp;
            godr_ff <= nxt_godr;
            gval_ff <= nxt_gval;
        end
    end

    // Mag poll setting
    always_ff @(posedge clk) begin
        if (reset) begin
            modr_ff <= RST_MODR;
            mval_ff <= mag_rate_ok(RST_MODR);
        end else begin
            modr_ff <= nxt_modr;
            mval_ff <= nxt_mval;
        end
    end

    // Outputs straight from the flops
    assign reg_rdata       = rdata_ff;
    assign reg_hit         = hit_ff;
    assign range_changed   = chg_ff;
    assign config_err_code = err_ff;
    assign accel_range_sel = acc_ff;
    assign gyro_bw_coef    = bwp_ff;
    assign gyro_rate_sel   = godr_ff;
    assign gyro_rate_valid = gval_ff;
    assign gyro_range_sel  = grng_ff;
    assign mag_poll_sel    = modr_ff;
    assign mag_poll_valid  = mval_ff;

endmodule

`default_nettype wire

// ==== dv/msrrc_top_sva.sv ====
// Port checker for the range and rate configuration slice.
// Assumes msrrc_pkg is compiled first; bound onto msrrc_top below.
`timescale 1ns/1ps
`default_nettype none
module msrrc_top_sva
    import msrrc_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       reg_hit,
    input wire logic       gyro_rate_valid,
    input wire logic       mag_poll_valid,
    input wire logic       range_changed,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] accel_range_sel,
    input wire logic [1:0] gyro_bw_coef,
    input wire logic [3:0] gyro_rate_sel,
    input wire logic [3:0] mag_poll_sel,
    input wire logic [3:0] config_err_code,
    input wire logic [2:0] gyro_range_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Write decodes per register
    wire w41 = reg_wr && reg_addr == ADDR_ACCEL_FULL_SCALE;
    wire w42 = reg_wr && reg_addr == ADDR_GYRO_RATE_FILTER;
    wire w43 = reg_wr && reg_addr == ADDR_GYRO_FULL_SCALE;
    wire w44 = reg_wr && reg_addr == ADDR_MAG_POLL_RATE;
    wire map = reg_addr inside {[ADDR_ACCEL_FULL_SCALE:ADDR_MAG_POLL_RATE]};
    a_accel_decode: assert property (w41 |=> accel_range_sel == (
        $past(reg_wdata[3:0]) == ACC_CODE_4G ? 2'h1 : $past(reg_wdata[3:0]) == ACC_CODE_8G ? 2'h2 :
        $past(reg_wdata[3:0]) == ACC_CODE_16G ? 2'h3 : 2'h0)) else $error("accel decode wrong");
    a_gyro_fields: assert property (w42 |=> {gyro_bw_coef, gyro_rate_sel} == $past(reg_wdata[5:0]))
        else $error("gyro fields wrong");
    a_gyro_valid: assert property (gyro_rate_valid == (gyro_rate_sel inside {[4'h6:4'hD]}))
        else $error("gyro rate valid wrong");
    a_gyro_range: assert property (w43 |=> gyro_range_sel == $past(reg_wdata[2:0]))
        else $error("gyro range wrong");
    a_mag_poll: assert property (w44 |=> mag_poll_sel == $past(reg_wdata[3:0]) &&
        mag_poll_valid == ($past(reg_wdata[3:0]) inside {[4'h1:4'hB]})) else $error("mag poll wrong");
    a_bad_config: assert property (!gyro_rate_valid || gyro_bw_coef == 2'h3 |-> config_err_code != 4'h0)
        else $error("illegal config not flagged");
    a_range_notice: assert property (range_changed == $past((w41 || w43) && !reset))
        else $error("range notice wrong");
    a_unmapped_port: assert property ((reg_rd || reg_wr) && !map |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped access answered");
    a_reset_values: assert property ($fell(reset) |-> accel_range_sel == 2'h0 && gyro_rate_sel == 4'h8 &&
        gyro_bw_coef == 2'h2 && gyro_range_sel == 3'h0 && mag_poll_sel == 4'hB) else $error("reset values wrong");
    // Main scenarios reached
    c_range_write: cover property (w41 ##1 range_changed);
    c_config_err: cover property (config_err_code != 4'h0);
    c_wr_and_rd: cover property (reg_rd && reg_wr && map);
endmodule
bind msrrc_top msrrc_top_sva u_sva (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_hit(reg_hit),
    .gyro_rate_valid(gyro_rate_valid), .mag_poll_valid(mag_poll_valid), .range_changed(range_changed),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .accel_range_sel(accel_range_sel),
    .gyro_bw_coef(gyro_bw_coef), .gyro_rate_sel(gyro_rate_sel), .mag_poll_sel(mag_poll_sel),
    .config_err_code(config_err_code), .gyro_range_sel(gyro_range_sel));
`default_nettype wire

// ==== dv/msrrc_top_test.sv ====
// Self-checking bench for the range and rate configuration slice.
// Assumes msrrc_pkg, msrrc_top and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module msrrc_top_test
    import msrrc_pkg::*;
;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, rc_q = 0, hit_q = 0;
    logic reg_hit, gyro_rate_valid, mag_poll_valid, range_changed;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_q [$];
    logic [1:0] accel_range_sel, gyro_bw_coef;
    logic [3:0] gyro_rate_sel, mag_poll_sel, config_err_code;
    logic [2:0] gyro_range_sel;
    logic [7:0] mdl [4];
    logic [31:0] seed = 32'd66619;
    int n_errors = 0, compares = 0;
    localparam logic [7:0] MSK [4] = '{8'h0F, 8'h3F, 8'h07, 8'h0F};
    localparam logic [7:0] RST [4] = '{8'h03, 8'h28, 8'h00, 8'h0B};
    msrrc_top dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .accel_range_sel(accel_range_sel),
        .gyro_bw_coef(gyro_bw_coef), .gyro_rate_sel(gyro_rate_sel), .gyro_rate_valid(gyro_rate_valid),
        .gyro_range_sel(gyro_range_sel), .mag_poll_sel(mag_poll_sel), .mag_poll_valid(mag_poll_valid),
        .config_err_code(config_err_code), .range_changed(range_changed));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One port cycle; read expectation noted before the write lands, as wr+rd returns old data
    task automatic op(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
        logic hit;
        logic [1:0] i;
        hit = a inside {[7'h41:7'h44]};
        i = a[1:0] - 2'h1;
        if (r) exp_q.push_back(hit ? mdl[i] : 8'h00);
        if (w && hit) mdl[i] = d & MSK[i];
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    // Decoded outputs against the bench model; called after a cycle with no write so they are settled
    task automatic fields();
        logic [3:0] c;
        logic gv, mv, gbad;
        logic [3:0] ecode;
        c = mdl[0][3:0];
        gv = mdl[1][3:0] inside {[4'h6:4'hD]};
        mv = mdl[3][3:0] inside {[4'h1:4'hB]};
        gbad = !gv || mdl[1][5:4] == 2'h3;
        ecode = gbad ? ERR_GYRO_RATE_FILTER_CONFIG : !mv ? ERR_MAGNETOMETER_POLL_RATE : mdl[2] > 8'h04 ? ERR_GYR_RANGE : ERR_NONE;
        chk("accel", {6'h0, accel_range_sel}, c == 4'h5 ? 8'h01 : c == 4'h8 ? 8'h02 : c == 4'hC ? 8'h03 : 8'h00);
        chk("gyro cfg", {2'h0, gyro_bw_coef, gyro_rate_sel}, mdl[1]);
        chk("gyro valid", {7'h0, gyro_rate_valid}, {7'h0, gv});
        chk("gyro range", {5'h0, gyro_range_sel}, mdl[2]);
        chk("mag poll", {3'h0, mag_poll_valid, mag_poll_sel}, {3'h0, mv, mdl[3][3:0]});
        chk("error code", {4'h0, config_err_code}, {4'h0, ecode});
    endtask
    // Monitor: oldest noted read value against read data, and the range notice
    always @(posedge clk) begin
        rd_q <= reg_rd;
        rc_q <= reg_wr && (reg_addr == 7'h41 || reg_addr == 7'h43);
        hit_q <= (reg_rd || reg_wr) && reg_addr inside {[7'h41:7'h44]};
    end
    always @(negedge clk) begin
        if (!reset) chk("range notice", {7'h0, range_changed}, {7'h0, rc_q});
        if (!reset) chk("port hit", {7'h0, reg_hit}, {7'h0, hit_q});
        if (rd_q && exp_q.size() > 0) chk("read data", reg_rdata, exp_q.pop_front());
    end
    task automatic results();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
    initial begin
        logic [31:0] rv;
        logic [6:0] ra;
        for (int k = 0; k < 2; k++) begin
            repeat (8) @(posedge clk);
            reset <= 1'b0;
            mdl = RST;
            for (int a = 0; a < 6; a++) op(1'b0, 1'b1, 7'(7'h40 + a), 8'h00);
            op(1'b0, 1'b0, 7'h00, 8'h00);
            fields();
            $display("test reset values done");
            // Every accel code, reserved bits clear, then random traffic incl. unmapped and wr+rd
            for (int n = 0; n < 160; n++) begin
                rv = rnd();
                ra = 7'(7'h40 + rv[15:8] % 6);
                if (n < 16) op(1'b1, 1'b1, ADDR_ACCEL_FULL_SCALE, {4'h0, n[3:0]});
                else op(1'b1, rv[0], ra, rv[31:24] & MSK[ra[1:0] - 2'h1]);
                // Read-back stands in for the data and indirect-access registers outside this slice
                op(1'b0, 1'b1, 7'(7'h40 + rv[23:16] % 6), 8'h00);
                fields();
            end
            op(1'b0, 1'b0, 7'h00, 8'h00);
            $display("test write traffic done");
            reset <= 1'b1;
        end
        repeat (2) @(posedge clk);
        results();
    end
endmodule
`default_nettype wire
